// ===== hdl/ircb_pkg.sv
package ircb_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int NUM_PORTS = 12;
    localparam int PORT_W = 4;
    localparam int ID_W = 5;
    localparam int NIB_W = 4;
    localparam int CNT_W = 4;
    localparam int VEC_SYNC_W = 19;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int REF_CLK_NS = 50;
    localparam int TURN_FLOAT_MIN_NS = 10;
    localparam int TURN_FLOAT_RAW = (TURN_FLOAT_MIN_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam logic [CNT_W-1:0] TURN_FLOAT_CYCLES =
        CNT_W'((TURN_FLOAT_RAW < 1) ? 1 : TURN_FLOAT_RAW);
    // Cycles the wired-AND vector needs to settle and pass the synchroniser.
    localparam logic [CNT_W-1:0] ARB_SETTLE_CYCLES = 4'h5;

    // ************************************************************
    // Management nibble layout
    // ************************************************************
    localparam int ID_LO_LSB = 0;
    localparam int ID_LO_MSB = 3;
    localparam int ID_HI_BIT = 4;
    localparam logic [2:0] NIB_HI_PAD = 3'h0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic XCVR_EN_N_RST = 1'h0;
    localparam logic DIR_RST = 1'h0;
    localparam logic ACT_N_RST = 1'h1;
    localparam logic ERR_N_RST = 1'h1;
    localparam logic [NIB_W-1:0] NIB_RST = 4'h0;

    typedef enum logic [1:0] {TA_INPUT, TA_FLOAT, TA_OUTPUT} ircb_ta_state_t;
    typedef enum logic [1:0] {MG_IDLE, MG_NIB0, MG_NIB1, MG_NIB2} ircb_mg_state_t;

endpackage

// ===== hdl/ircb_sync3.sv
`timescale 1ns/1ps
module ircb_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    always_ff @(posedge clk_in) begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // A bit only moves once the second and third stage agree on it.
    always_ff @(posedge clk_in) begin
        out_q <= (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
    end

    assign sync_out = out_q;
endmodule

// ===== hdl/ircb_mgmt_tx.sv
`timescale 1ns/1ps
module ircb_mgmt_tx (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [ircb_pkg::ID_W-1:0] id_in,
    input wire logic [ircb_pkg::PORT_W-1:0] port_in,
    output logic [ircb_pkg::NIB_W-1:0] data_out,
    output logic oe_out
);
    ircb_pkg::ircb_mg_state_t state_q;
    logic [ircb_pkg::NIB_W-1:0] data_q;
    logic oe_q;

    always_ff @(posedge clk_in) begin
        if (srst_in || abort_in) begin
            state_q <= ircb_pkg::MG_IDLE;
            data_q <= ircb_pkg::NIB_RST;
            oe_q <= 1'h0;
        end else begin
            case (state_q)
                ircb_pkg::MG_IDLE: begin
                    oe_q <= 1'h0;
                    if (start_in) begin
                        state_q <= ircb_pkg::MG_NIB0;
                        data_q <= id_in[ircb_pkg::ID_LO_MSB:ircb_pkg::ID_LO_LSB];
                        oe_q <= 1'h1;
                    end
                end
                ircb_pkg::MG_NIB0: begin
                    state_q <= ircb_pkg::MG_NIB1;
                    data_q <= {ircb_pkg::NIB_HI_PAD, id_in[ircb_pkg::ID_HI_BIT]};
                end
                ircb_pkg::MG_NIB1: begin
                    state_q <= ircb_pkg::MG_NIB2;
                    data_q <= port_in;
                end
                ircb_pkg::MG_NIB2: begin
                    state_q <= ircb_pkg::MG_IDLE;
                    data_q <= ircb_pkg::NIB_RST;
                    oe_q <= 1'h0;
                end
                default: begin
                    state_q <= ircb_pkg::MG_IDLE;
                    oe_q <= 1'h0;
                end
            endcase
        end
    end

    assign data_out = data_q;
    assign oe_out = oe_q;
endmodule

// ===== hdl/ircb_cascade.sv
`timescale 1ns/1ps
module ircb_cascade (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic cascade_clk_in,
    input wire logic [ircb_pkg::NUM_PORTS-1:0] port_crs_in,
    input wire logic [ircb_pkg::ID_W-1:0] repeater_id_in,
    input wire logic [ircb_pkg::NIB_W-1:0] rx_nibble_in,
    input wire logic rx_err_in,
    input wire logic rx_dv_in,
    input wire logic [ircb_pkg::NIB_W-1:0] cascade_data_in,
    output logic [ircb_pkg::NIB_W-1:0] cascade_data_out,
    output logic cascade_data_oe_out,
    input wire logic cascade_err_in,
    output logic cascade_err_out,
    output logic cascade_err_oe_out,
    input wire logic cascade_dv_in,
    output logic cascade_dv_out,
    output logic cascade_dv_oe_out,
    output logic cascade_dir_out,
    output logic cascade_xcvr_en_n_out,
    input wire logic [ircb_pkg::ID_W-1:0] cascade_id_vector_n_in,
    output logic [ircb_pkg::ID_W-1:0] cascade_id_vector_n_out,
    output logic [ircb_pkg::ID_W-1:0] cascade_id_vector_n_oe_out,
    input wire logic cascade_activity_n_in,
    output logic cascade_activity_n_out,
    input wire logic cascade_collision_n_in,
    output logic cascade_collision_out_n_out,
    output logic port_active_out_n_out,
    output logic [ircb_pkg::NIB_W-1:0] tx_nibble_out,
    output logic tx_err_out,
    output logic tx_dv_out,
    output logic tx_enable_out,
    output logic collision_seen_out,
    output logic [ircb_pkg::NIB_W-1:0] mgmt_data_out,
    output logic mgmt_oe_out,
    output logic id_contention_err_out,
    input wire logic eb_underrun_in,
    input wire logic eb_overrun_in,
    output logic mgmt_buffer_err_n_out
);

    // ************************************************************
    // Port decoding
    // ************************************************************
    function automatic logic [ircb_pkg::PORT_W-1:0] active_count(
        input logic [ircb_pkg::NUM_PORTS-1:0] crs
    );
        logic [ircb_pkg::PORT_W-1:0] n;
        n = '0;
        for (int i = 0; i < ircb_pkg::NUM_PORTS; i++) begin
            n = n + ircb_pkg::PORT_W'(crs[i]);
        end
        return n;
    endfunction

    function automatic logic [ircb_pkg::PORT_W-1:0] active_index(
        input logic [ircb_pkg::NUM_PORTS-1:0] crs
    );
        logic [ircb_pkg::PORT_W-1:0] idx;
        idx = '0;
        for (int i = 0; i < ircb_pkg::NUM_PORTS; i++) begin
            if (crs[i]) begin
                idx = ircb_pkg::PORT_W'(i);
            end
        end
        return idx;
    endfunction

    // ************************************************************
    // Pin synchronisers on the local clock
    // ************************************************************
    logic [ircb_pkg::NUM_PORTS-1:0] crs_s;
    logic [ircb_pkg::ID_W-1:0] vect_n_s;
    logic others_act_s;
    logic col_in_s;

    ircb_sync3 #(
        .W(ircb_pkg::VEC_SYNC_W)
    ) u_ref_sync (
        .clk_in(ref_clk_in),
        .async_in({port_crs_in, cascade_id_vector_n_in,
                   ~cascade_activity_n_in, ~cascade_collision_n_in}),
        .sync_out({crs_s, vect_n_s, others_act_s, col_in_s})
    );

    logic [ircb_pkg::PORT_W-1:0] n_active;
    logic any_active;
    logic one_active;
    logic multi_active;

    always_comb begin
        n_active = active_count(crs_s);
        any_active = (n_active != '0);
        one_active = (n_active == ircb_pkg::PORT_W'(1));
        multi_active = any_active && !one_active;
    end

    // ************************************************************
    // Repeater identity strap
    // ************************************************************
    // The strap is sampled for as long as reset is held, so the last
    // value before release is kept.
    logic [ircb_pkg::ID_W-1:0] id_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            id_q <= repeater_id_in;
        end
    end

    // ************************************************************
    // Vector arbitration
    // ************************************************************
    logic own_rx_q;
    logic [ircb_pkg::CNT_W-1:0] settle_q;
    logic settled;
    logic lost_q;
    logic mismatch_async;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            own_rx_q <= 1'h0;
        end else begin
            own_rx_q <= one_active;
        end
    end

    // One counter serves both our own arbitration and watching others:
    // it runs while we receive on a single port or another chip is active, and saturates.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !(own_rx_q || others_act_s)) begin
            settle_q <= '0;
        end else if (settle_q != ircb_pkg::ARB_SETTLE_CYCLES) begin
            settle_q <= settle_q + ircb_pkg::CNT_W'(1);
        end
    end

    assign settled = (settle_q == ircb_pkg::ARB_SETTLE_CYCLES);

    // Each bit that is zero in our ID pulls its line low; a one only
    // releases it, so the bus shows the AND of all drivers.
    generate
        for (genvar b = 0; b < ircb_pkg::ID_W; b++) begin : g_vect
            assign cascade_id_vector_n_out[b] = 1'h0;
            assign cascade_id_vector_n_oe_out[b] = own_rx_q && !id_q[b];
        end
    endgenerate

    // Compared straight on the pins so a second receiver is seen
    // without waiting for the local clock.
    assign mismatch_async = own_rx_q && (cascade_id_vector_n_in != id_q);

    // The clocked copy waits for the lines to settle before it may
    // declare a loss; otherwise the released all-ones state before our
    // own drive lands would look like a mismatch.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !own_rx_q) begin
            lost_q <= 1'h0;
        end else if (settled && (vect_n_s != id_q)) begin
            lost_q <= 1'h1;
        end
    end

    // ************************************************************
    // Bus ownership and turnaround
    // ************************************************************
    logic drive_req;
    logic drive_req_q;
    ircb_pkg::ircb_ta_state_t ta_state_q;
    logic [ircb_pkg::CNT_W-1:0] ta_cnt_q;
    logic dir_q;
    logic xcvr_en_n_q;

    assign drive_req = own_rx_q && settled && !lost_q && !multi_active
                       && !col_in_s;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ta_state_q <= ircb_pkg::TA_INPUT;
            ta_cnt_q <= '0;
            dir_q <= ircb_pkg::DIR_RST;
            xcvr_en_n_q <= ircb_pkg::XCVR_EN_N_RST;
        end else begin
            case (ta_state_q)
                ircb_pkg::TA_INPUT: begin
                    dir_q <= 1'h0;
                    xcvr_en_n_q <= 1'h0;
                    if (drive_req) begin
                        ta_state_q <= ircb_pkg::TA_FLOAT;
                        ta_cnt_q <= ircb_pkg::TURN_FLOAT_CYCLES;
                        xcvr_en_n_q <= 1'h1;
                    end
                end
                ircb_pkg::TA_FLOAT: begin
                    if (!drive_req) begin
                        ta_state_q <= ircb_pkg::TA_INPUT;
                        xcvr_en_n_q <= 1'h0;
                    end else if (ta_cnt_q <= ircb_pkg::CNT_W'(1)) begin
                        ta_state_q <= ircb_pkg::TA_OUTPUT;
                        dir_q <= 1'h1;
                        xcvr_en_n_q <= 1'h0;
                    end else begin
                        ta_cnt_q <= ta_cnt_q - ircb_pkg::CNT_W'(1);
                    end
                end
                ircb_pkg::TA_OUTPUT: begin
                    if (!drive_req) begin
                        ta_state_q <= ircb_pkg::TA_INPUT;
                        dir_q <= 1'h0;
                    end
                end
                default: begin
                    ta_state_q <= ircb_pkg::TA_INPUT;
                    dir_q <= 1'h0;
                    xcvr_en_n_q <= 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            drive_req_q <= 1'h0;
        end else begin
            drive_req_q <= drive_req;
        end
    end

    // ************************************************************
    // Status lines
    // ************************************************************
    logic act_n_q;
    logic col_seen_q;
    logic buf_err_n_q;
    logic contention_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            act_n_q <= ircb_pkg::ACT_N_RST;
        end else begin
            act_n_q <= !any_active;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            col_seen_q <= 1'h0;
        end else begin
            col_seen_q <= multi_active || col_in_s || lost_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            buf_err_n_q <= ircb_pkg::ERR_N_RST;
        end else begin
            buf_err_n_q <= !(eb_underrun_in || eb_overrun_in);
        end
    end

    // Sticky until reset: a duplicate ID is a configuration fault.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            contention_q <= 1'h0;
        end else if (!own_rx_q && others_act_s && settled && (vect_n_s == id_q)) begin
            contention_q <= 1'h1;
        end
    end

    // The loss term is left unclocked so a second receiver is told at
    // once, at the price of possible glitches while the lines settle.
    assign cascade_collision_out_n_out = !(multi_active || mismatch_async
                                           || lost_q);
    assign cascade_activity_n_out = act_n_q;
    assign port_active_out_n_out = act_n_q;
    assign collision_seen_out = col_seen_q;
    assign mgmt_buffer_err_n_out = buf_err_n_q;
    assign id_contention_err_out = contention_q;
    assign cascade_dir_out = dir_q;
    assign cascade_xcvr_en_n_out = xcvr_en_n_q;

    // ************************************************************
    // Management bus
    // ************************************************************
    logic mg_start;
    logic mg_abort;

    assign mg_start = drive_req && !drive_req_q;
    assign mg_abort = multi_active || col_in_s || lost_q;

    ircb_mgmt_tx u_mgmt (
        .clk_in(ref_clk_in),
        .srst_in(srst_in),
        .start_in(mg_start),
        .abort_in(mg_abort),
        .id_in(id_q),
        .port_in(active_index(crs_s)),
        .data_out(mgmt_data_out),
        .oe_out(mgmt_oe_out)
    );

    // ************************************************************
    // Link clock domain
    // ************************************************************
    logic link_drive_s;
    logic link_rst_s;

    ircb_sync3 #(
        .W(2)
    ) u_link_sync (
        .clk_in(cascade_clk_in),
        .async_in({dir_q, srst_in}),
        .sync_out({link_drive_s, link_rst_s})
    );

    logic [ircb_pkg::NIB_W-1:0] out_nib_q;
    logic out_err_q;
    logic out_dv_q;
    logic out_oe_q;
    logic [ircb_pkg::NIB_W-1:0] in_nib_q;
    logic in_err_q;
    logic in_dv_q;
    logic in_en_q;

    // One launch flop only, so error and valid keep step with the data.
    always_ff @(posedge cascade_clk_in) begin
        if (link_rst_s || !link_drive_s) begin
            out_nib_q <= ircb_pkg::NIB_RST;
            out_err_q <= 1'h0;
            out_dv_q <= 1'h0;
            out_oe_q <= 1'h0;
        end else begin
            out_nib_q <= rx_nibble_in;
            out_err_q <= rx_err_in;
            out_dv_q <= rx_dv_in;
            out_oe_q <= 1'h1;
        end
    end

    always_ff @(posedge cascade_clk_in) begin
        if (link_rst_s || link_drive_s) begin
            in_nib_q <= ircb_pkg::NIB_RST;
            in_err_q <= 1'h0;
            in_dv_q <= 1'h0;
            in_en_q <= 1'h0;
        end else begin
            in_nib_q <= cascade_data_in;
            in_err_q <= cascade_err_in;
            in_dv_q <= cascade_dv_in;
            in_en_q <= 1'h1;
        end
    end

    // Gating with the local direction lets the drive drop the moment
    // ownership is lost, instead of a few link edges later.
    assign cascade_data_out = out_nib_q;
    assign cascade_err_out = out_err_q;
    assign cascade_dv_out = out_dv_q;
    assign cascade_data_oe_out = out_oe_q && dir_q;
    assign cascade_err_oe_out = out_oe_q && dir_q;
    assign cascade_dv_oe_out = out_oe_q && dir_q;
    assign tx_nibble_out = in_nib_q;
    assign tx_err_out = in_err_q;
    assign tx_dv_out = in_dv_q;
    assign tx_enable_out = in_en_q;

endmodule

// ===== test/ircb_cascade_assertions.sv
`timescale 1ns/1ps
module ircb_cascade_assertions (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [11:0] port_crs_in,
    input wire logic [4:0] repeater_id_in,
    input wire logic cascade_collision_n_in,
    input wire logic eb_underrun_in,
    input wire logic eb_overrun_in,
    input wire logic cascade_data_oe_out,
    input wire logic cascade_dir_out,
    input wire logic cascade_xcvr_en_n_out,
    input wire logic [4:0] cascade_id_vector_n_oe_out,
    input wire logic cascade_activity_n_out,
    input wire logic port_active_out_n_out,
    input wire logic cascade_collision_out_n_out,
    input wire logic [3:0] mgmt_data_out,
    input wire logic mgmt_oe_out,
    input wire logic id_contention_err_out,
    input wire logic mgmt_buffer_err_n_out
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    logic [4:0] id_q;
    // The strap is only taken while reset is high, so later changes are ignored.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            id_q <= repeater_id_in;
        end
    end
    a_dir_after_float: assert property ($rose(cascade_dir_out) |-> $past(cascade_xcvr_en_n_out))
        else $error("direction rose without a float cycle");
    a_float_is_brief: assert property ($rose(cascade_xcvr_en_n_out) |=>
        (cascade_dir_out && !cascade_xcvr_en_n_out))
        else $error("float did not end with output direction");
    a_active_pair: assert property (port_active_out_n_out == cascade_activity_n_out)
        else $error("active and activity outputs differ");
    a_vector_open: assert property (cascade_id_vector_n_oe_out != 5'h00 |->
        cascade_id_vector_n_oe_out == ~id_q)
        else $error("vector enables do not match zero id bits");
    // The vector drops with the port one edge before direction does, so the
    // owner is judged on the vector it drove a cycle earlier.
    a_owner_vector: assert property (cascade_dir_out |->
        $past(cascade_id_vector_n_oe_out) == ~id_q)
        else $error("owner not driving its vector");
    a_data_oe_dir: assert property (cascade_data_oe_out |-> cascade_dir_out)
        else $error("data driven while not owning");
    a_buf_err_low: assert property ((eb_underrun_in || eb_overrun_in) |=>
        !mgmt_buffer_err_n_out)
        else $error("buffer error not flagged");
    a_mgmt_order: assert property ($rose(mgmt_oe_out) |-> mgmt_data_out == id_q[3:0] ##1
        (!mgmt_oe_out || mgmt_data_out == {3'h0, id_q[4]}))
        else $error("management nibble order wrong");
    a_mgmt_col_off: assert property ($fell(cascade_collision_n_in) |-> ##[1:6] !mgmt_oe_out)
        else $error("management bus driven in collision");
    a_multi_col: assert property (($countones(port_crs_in) > 1) [*6] |->
        !cascade_collision_out_n_out)
        else $error("no collision on multiple ports");
    a_act_ports: assert property ((|port_crs_in) [*6] |-> !cascade_activity_n_out)
        else $error("activity not shown");
    a_contend_idle: assert property ($rose(id_contention_err_out) |-> !$past(cascade_dir_out))
        else $error("contention flagged while owning");
    c_own: cover property ($rose(cascade_dir_out));
    c_mgmt: cover property ($rose(mgmt_oe_out));
    c_dup: cover property ($rose(id_contention_err_out));
endmodule

// ===== test/ircb_far_chip.sv
`timescale 1ns/1ps
module ircb_far_chip (
    input wire logic link_clk_in,
    input wire logic rx_in,
    input wire logic [4:0] id_in,
    input wire logic [4:0] vec_n_in,
    output logic [4:0] vec_oe_out,
    output logic activity_n_out,
    output logic collision_n_out,
    output logic [3:0] data_out,
    output logic dv_out
);
    // ************************************************************
    // Remote chip
    // ************************************************************
    logic [3:0] cnt_q = 4'h0;
    logic drive;
    assign vec_oe_out = rx_in ? ~id_in : 5'h00;
    assign activity_n_out = ~rx_in;
    assign collision_n_out = ~(rx_in && (vec_n_in != id_in));
    assign drive = rx_in && collision_n_out;
    assign dv_out = drive;
    always @(posedge link_clk_in) begin
        cnt_q <= cnt_q + 4'h1;
    end
    // Released lines change every cycle so a stale sample cannot pass.
    assign data_out = drive ? cnt_q : ~cnt_q;
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
bind ircb_cascade ircb_cascade_assertions ircb_cascade_assertions_i (.ref_clk_in, .srst_in,
    .port_crs_in, .repeater_id_in, .cascade_collision_n_in, .eb_underrun_in, .eb_overrun_in,
    .cascade_data_oe_out, .cascade_dir_out, .cascade_xcvr_en_n_out,
    .cascade_id_vector_n_oe_out, .cascade_activity_n_out, .port_active_out_n_out,
    .cascade_collision_out_n_out, .mgmt_data_out, .mgmt_oe_out, .id_contention_err_out,
    .mgmt_buffer_err_n_out);
module testbench;
    // ************************************************************
    // Stimulus and wiring
    // ************************************************************
    logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, rxe = 1'b0, rxv = 1'b0;
    logic urun = 1'b0, orun = 1'b0, frx = 1'b0;
    logic [11:0] crs = 12'h000;
    logic [4:0] repeater_id = 5'h12, fid = 5'h05, vec_o, vec_oe, f_oe, vec;
    logic [3:0] rxn = 4'h0, d_o, txn, md, f_d, bus;
    logic d_oe, e_o, e_oe, v_o, v_oe, dir, xen, act_n, f_act_n, col_n, f_col_n, pact_n;
    logic tx_en, col_seen, moe, cerr, berr_n, f_dv, txe, txv;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    assign vec = ~((vec_oe & ~vec_o) | f_oe);
    assign bus = d_oe ? d_o : f_d;
    always #25 clk = ~clk;
    always #16 lclk = ~lclk;
    ircb_cascade ircb_cascade_i (.ref_clk_in(clk), .srst_in(rst), .cascade_clk_in(lclk),
        .port_crs_in(crs), .repeater_id_in(repeater_id), .rx_nibble_in(rxn), .rx_err_in(rxe),
        .rx_dv_in(rxv), .cascade_data_in(bus), .cascade_data_out(d_o),
        .cascade_data_oe_out(d_oe), .cascade_err_in(e_oe ? e_o : ~f_dv),
        .cascade_err_out(e_o), .cascade_err_oe_out(e_oe),
        .cascade_dv_in(v_oe ? v_o : f_dv), .cascade_dv_out(v_o), .cascade_dv_oe_out(v_oe),
        .cascade_dir_out(dir), .cascade_xcvr_en_n_out(xen), .cascade_id_vector_n_in(vec),
        .cascade_id_vector_n_out(vec_o), .cascade_id_vector_n_oe_out(vec_oe),
        .cascade_activity_n_in(f_act_n), .cascade_activity_n_out(act_n),
        .cascade_collision_n_in(f_col_n), .cascade_collision_out_n_out(col_n),
        .port_active_out_n_out(pact_n), .tx_nibble_out(txn), .tx_err_out(txe), .tx_dv_out(txv),
        .tx_enable_out(tx_en), .collision_seen_out(col_seen), .mgmt_data_out(md),
        .mgmt_oe_out(moe), .id_contention_err_out(cerr), .eb_underrun_in(urun),
        .eb_overrun_in(orun), .mgmt_buffer_err_n_out(berr_n));
    ircb_far_chip ircb_far_chip_i (.link_clk_in(lclk), .rx_in(frx), .id_in(fid),
        .vec_n_in(vec), .vec_oe_out(f_oe), .activity_n_out(f_act_n),
        .collision_n_out(f_col_n), .data_out(f_d), .dv_out(f_dv));
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [4:0] g, input logic [4:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The whole run needs well under a thousand local cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_own();
        int i;
        @(posedge clk) crs <= 12'h008;
        for (i = 0; i < 40 && moe !== 1'b1; i++) @(negedge clk);
        check(md, 5'h02);
        @(negedge clk) check(md, 5'h01);
        @(negedge clk) check(md, 5'h03);
        @(negedge clk) check(moe, 5'h00);
        for (i = 0; i < 20 && dir !== 1'b1; i++) @(negedge clk);
        check(dir, 5'h01);
        check(xen, 5'h00);
        check(act_n, 5'h00);
        check(pact_n, 5'h00);
        check(col_n, 5'h01);
        repeat (8) @(posedge lclk);
        check(tx_en, 5'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge lclk);
            rxn <= 4'(i + 9);
            rxe <= i[0];
            rxv <= 1'b1;
            @(posedge lclk);
            @(negedge lclk);
            check(bus, 5'(i + 9));
            check(d_oe, 5'h01);
            check(e_o, 5'(i[0]));
            check(v_o, 5'h01);
        end
        @(posedge lclk) rxv <= 1'b0;
        @(posedge clk) crs <= 12'h000;
        for (i = 0; i < 20 && dir !== 1'b0; i++) @(negedge clk);
        check(dir, 5'h00);
    endtask
    task automatic t_multi();
        @(posedge clk) crs <= 12'h011;
        repeat (12) @(negedge clk);
        check(col_n, 5'h00);
        check(dir, 5'h00);
        check(moe, 5'h00);
        @(posedge clk) crs <= 12'h000;
        repeat (12) @(negedge clk);
    endtask
    task automatic t_far();
        logic [3:0] b;
        @(posedge clk) frx <= 1'b1;
        repeat (20) @(negedge clk);
        check(dir, 5'h00);
        check(tx_en, 5'h01);
        check(cerr, 5'h00);
        @(negedge lclk) b = bus;
        @(negedge lclk) check(txn, b);
        check(txv, 5'h01);
        check(txe, 5'h00);
        @(posedge clk) frx <= 1'b0;
        repeat (12) @(negedge clk);
    endtask
    task automatic t_clash();
        @(posedge clk) crs <= 12'h001;
        frx <= 1'b1;
        repeat (20) @(negedge clk);
        check(col_n, 5'h00);
        check(dir, 5'h00);
        check(d_oe, 5'h00);
        check(col_seen, 5'h01);
        check(moe, 5'h00);
        @(posedge clk) crs <= 12'h000;
        frx <= 1'b0;
        repeat (12) @(negedge clk);
    endtask
    task automatic t_buf();
        @(posedge clk) urun <= 1'b1;
        @(posedge clk) urun <= 1'b0;
        @(negedge clk) check(berr_n, 5'h00);
        @(posedge clk) orun <= 1'b1;
        @(posedge clk) orun <= 1'b0;
        @(negedge clk) check(berr_n, 5'h00);
        repeat (3) @(negedge clk);
        check(berr_n, 5'h01);
    endtask
    task automatic t_dup();
        @(posedge clk) fid <= 5'h12;
        frx <= 1'b1;
        repeat (20) @(negedge clk);
        check(cerr, 5'h01);
        @(posedge clk) frx <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        check(dir, 5'h00);
        check(xen, 5'h00);
        check(act_n, 5'h01);
        t_own();
        t_multi();
        t_far();
        t_clash();
        t_buf();
        t_dup();
        stop_test();
    end
endmodule
